// >>> iawm_mapper.sv
// Crank angle reference, firing window gating and cam edge capture with APB registers
//
// Notes on behaviour
// - Hold a signed offset from tracker zero to first cylinder top center.
// - Hold twelve cylinder top-center angles relative to the first cylinder.
// - Angles bind to no channel except through a per-channel selector.
// - Every direct channel has its own selector choosing one of twelve angles.
// - At most one channel of a direct module fires at once.
// - Direct injection only passes while crank angle is inside its window.
// - One start and end per direct module, placed around each channel.
// - Direct window angles count degrees before the selected top center.
// - Flag overlap when windows inside any direct module overlap.
// - At most one of the four port channels fires at once.
// - Each port channel has its own top-center selector.
// - Port module window in degrees before selected center gates injection.
// - Flag overlap when the port channels' windows overlap.
// - Cam capture reference is selectable among the twelve angles.
// - A start angle opens the first cam rising-edge search window.
// - Report the crank angle of a captured cam edge before top center.
// - An end angle closes the cam rising-edge search window.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module iawm_mapper
   import iawm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [9:0] engine_angle,
   input wire logic angle_valid,
   input wire logic [11:0] di_request,
   input wire logic [3:0] pfi_request,
   input wire logic cam1_in,
   output logic [11:0] di_fire,
   output logic [3:0] pfi_fire,
   output logic overlap_detected,
   output logic cam_edge_seen,
   output logic signed [10:0] first_cam_edge_angle
);

   ////////////////////////////////////////////////////////////////////////////
   // Angle helpers

   // Folds any sum of a few angles into 0..719
   function automatic logic [9:0] wrap(input logic signed [13:0] x);
      logic signed [13:0] v;
      v = x;
      for (int i = 0; i < IAWM_WRAP_STEPS; i++) begin
         if (v < 14'sh0000) begin
            v = v + IAWM_CYCLE;
         end
      end
      for (int i = 0; i < IAWM_WRAP_STEPS; i++) begin
         if (v >= IAWM_CYCLE) begin
            v = v - IAWM_CYCLE;
         end
      end
      return v[9:0];
   endfunction

   function automatic logic signed [13:0] ext(input logic [9:0] a);
      return $signed({4'h0, a});
   endfunction

   // Degrees before a top center at absolute angle ref
   function automatic logic [9:0] before_tc(input logic [9:0] ref_abs, input logic [9:0] ang);
      return wrap(ext(ref_abs) - ext(ang));
   endfunction

   function automatic logic [9:0] span_of(input iawm_window_t w);
      return wrap(14'(w.start) - 14'(w.stop));
   endfunction

   // Window runs from start down to stop in degrees before top center
   function automatic logic in_win(input logic [9:0] d, input iawm_window_t w);
      return wrap(14'(w.start) - ext(d)) <= span_of(w);
   endfunction

   // Two equal-span windows whose centers are apart overlap when the gap is short
   function automatic logic clash(input logic [9:0] a, input logic [9:0] b,
                                  input logic [9:0] span);
      return (wrap(ext(a) - ext(b)) <= span) || (wrap(ext(b) - ext(a)) <= span);
   endfunction

   function automatic logic [3:0] pick(input logic [3:0] s);
      return (s < 4'(IAWM_TDC_NUM)) ? s : 4'h0;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers

   logic gate_en;
   logic signed [10:0] zero_to_first_cylinder_offset;
   logic signed [10:0] cylinder_top_center_angle [IAWM_TDC_NUM];
   logic [3:0] direct_channel_reference_select [IAWM_DI_CHANS];
   logic [3:0] port_channel_reference_select [IAWM_PFI_CHANS];
   logic [3:0] cam_capture_reference_select;
   iawm_window_t direct_module_window [IAWM_DI_MODS];
   iawm_window_t port_module_window;
   iawm_window_t cam_window;

   logic access;
   logic wr_now;
   logic hit;
   logic cam_clear;
   logic [31:0] rd_word;

   assign access = psel & penable;
   assign wr_now = access & pready & pwrite;
   assign cam_clear = wr_now & (paddr == IAWM_STAT_ADDR) & pwdata[IAWM_STAT_CAM_BIT];

   // Writes land only at the completing edge of the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_en <= IAWM_CTRL_EN_RST;
         zero_to_first_cylinder_offset <= IAWM_OFFSET_RST;
         cylinder_top_center_angle <= IAWM_TDC_RST;
         for (int i = 0; i < IAWM_DI_CHANS; i++) begin
            direct_channel_reference_select[i] <= 4'(i);
         end
         for (int i = 0; i < IAWM_PFI_CHANS; i++) begin
            port_channel_reference_select[i] <= 4'(i);
         end
         cam_capture_reference_select <= IAWM_CAM_REF_RST;
         for (int i = 0; i < IAWM_DI_MODS; i++) begin
            direct_module_window[i] <= IAWM_DI_WIN_RST;
         end
         port_module_window <= IAWM_PFI_WIN_RST;
         cam_window <= IAWM_CAM_WIN_RST;
      end else if (wr_now) begin
         if (paddr == IAWM_CTRL_ADDR) begin
            gate_en <= pwdata[IAWM_CTRL_EN_BIT];
         end
         if (paddr == IAWM_OFFSET_ADDR) begin
            zero_to_first_cylinder_offset <= pwdata[10:0];
         end
         for (int i = 0; i < IAWM_TDC_NUM; i++) begin
            if (paddr == IAWM_TDC_BASE + 8'(4 * i)) begin
               cylinder_top_center_angle[i] <= pwdata[10:0];
            end
         end
         for (int i = 0; i < IAWM_DI_CHANS; i++) begin
            if (paddr == ((i < 8) ? IAWM_DI_SEL0_ADDR : IAWM_DI_SEL1_ADDR)) begin
               direct_channel_reference_select[i] <= pwdata[(i % 8) * 4 +: 4];
            end
         end
         if (paddr == IAWM_PFI_SEL_ADDR) begin
            for (int i = 0; i < IAWM_PFI_CHANS; i++) begin
               port_channel_reference_select[i] <= pwdata[i * 4 +: 4];
            end
            cam_capture_reference_select <= pwdata[IAWM_CAM_REF_LSB +: 4];
         end
         for (int i = 0; i < IAWM_DI_MODS; i++) begin
            if (paddr == IAWM_DI_WIN_BASE + 8'(4 * i)) begin
               direct_module_window[i].start <= pwdata[IAWM_WIN_START_LSB +: 11];
               direct_module_window[i].stop <= pwdata[IAWM_WIN_STOP_LSB +: 11];
            end
         end
         if (paddr == IAWM_PFI_WIN_ADDR) begin
            port_module_window.start <= pwdata[IAWM_WIN_START_LSB +: 11];
            port_module_window.stop <= pwdata[IAWM_WIN_STOP_LSB +: 11];
         end
         if (paddr == IAWM_CAM_WIN_ADDR) begin
            cam_window.start <= pwdata[IAWM_WIN_START_LSB +: 11];
            cam_window.stop <= pwdata[IAWM_WIN_STOP_LSB +: 11];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Angle and window evaluation

   logic [9:0] tc_abs [IAWM_TDC_NUM];
   logic [9:0] di_ref [IAWM_DI_CHANS];
   logic [9:0] pfi_ref [IAWM_PFI_CHANS];
   logic [9:0] cam_degrees_before_top_center;
   logic [11:0] di_in;
   logic [3:0] pfi_in;
   logic [11:0] di_allow;
   logic [3:0] pfi_allow;
   logic [11:0] next_di_fire;
   logic [3:0] next_pfi_fire;
   logic [3:0] di_clash;
   logic pfi_clash;
   logic [3:0] di_multi;
   logic pfi_multi;
   logic cam_in;

   // Absolute position of every cylinder's top center, then channel binding
   always_comb begin
      for (int k = 0; k < IAWM_TDC_NUM; k++) begin
         tc_abs[k] = wrap(14'(zero_to_first_cylinder_offset)
                          + 14'(cylinder_top_center_angle[k]));
      end
      for (int c = 0; c < IAWM_DI_CHANS; c++) begin
         di_ref[c] = tc_abs[pick(direct_channel_reference_select[c])];
         di_in[c] = in_win(before_tc(di_ref[c], engine_angle),
                           direct_module_window[c / 3]);
      end
      for (int c = 0; c < IAWM_PFI_CHANS; c++) begin
         pfi_ref[c] = tc_abs[pick(port_channel_reference_select[c])];
         pfi_in[c] = in_win(before_tc(pfi_ref[c], engine_angle), port_module_window);
      end
      cam_degrees_before_top_center = before_tc(tc_abs[pick(cam_capture_reference_select)], engine_angle);
      cam_in = in_win(cam_degrees_before_top_center, cam_window);
   end

   // Request passes only inside its window; lowest channel wins a tie
   always_comb begin
      di_allow = di_request & di_in & {12{gate_en & angle_valid}};
      pfi_allow = pfi_request & pfi_in & {4{gate_en & angle_valid}};
      for (int m = 0; m < IAWM_DI_MODS; m++) begin
         next_di_fire[m * 3 +: 3] = di_allow[m * 3 +: 3]
                                    & (~di_allow[m * 3 +: 3] + 3'h1);
         di_multi[m] = !$onehot0(di_in[m * 3 +: 3]);
      end
      next_pfi_fire = pfi_allow & (~pfi_allow + 4'h1);
      pfi_multi = !$onehot0(pfi_in);
   end

   // Static check of the configured windows, plus a live check as backup
   always_comb begin
      for (int m = 0; m < IAWM_DI_MODS; m++) begin
         di_clash[m] = clash(di_ref[3 * m], di_ref[3 * m + 1], span_of(direct_module_window[m]))
                     | clash(di_ref[3 * m + 1], di_ref[3 * m + 2],
                             span_of(direct_module_window[m]))
                     | clash(di_ref[3 * m], di_ref[3 * m + 2],
                             span_of(direct_module_window[m]));
      end
      pfi_clash = 1'b0;
      for (int a = 0; a < IAWM_PFI_CHANS; a++) begin
         for (int b = a + 1; b < IAWM_PFI_CHANS; b++) begin
            pfi_clash = pfi_clash
                        | clash(pfi_ref[a], pfi_ref[b], span_of(port_module_window));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Gated channel outputs and overlap flag

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         di_fire <= 12'h000;
         pfi_fire <= 4'h0;
      end else begin
         di_fire <= next_di_fire;
         pfi_fire <= next_pfi_fire;
      end
   end

   // Level flag; follows the configuration, so it clears once windows are fixed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overlap_detected <= 1'b0;
      end else begin
         overlap_detected <= (|di_clash) | (|di_multi) | pfi_clash | pfi_multi;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cam rising-edge capture

   logic cam1_q;
   logic cam_rise;
   logic signed [10:0] cam_signed;

   assign cam_rise = cam1_in & ~cam1_q & angle_valid;
   // Shown as -360..359 so an edge just after center reads negative
   assign cam_signed = (cam_degrees_before_top_center >= IAWM_HALF_CYCLE)
                       ? 11'($signed({1'b0, cam_degrees_before_top_center}) - 11'sh2D0)
                       : $signed({1'b0, cam_degrees_before_top_center});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cam1_q <= 1'b0;
      end else begin
         cam1_q <= cam1_in;
      end
   end

   // Latest edge in the window replaces the previous one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_cam_edge_angle <= 11'sh000;
      end else if (cam_rise && cam_in) begin
         first_cam_edge_angle <= cam_signed;
      end
   end

   // Sticky seen flag; a new edge beats a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cam_edge_seen <= 1'b0;
      end else if (cam_rise && cam_in) begin
         cam_edge_seen <= 1'b1;
      end else if (cam_clear) begin
         cam_edge_seen <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, registered read data

   always_comb begin
      rd_word = 32'h0000_0000;
      hit = 1'b1;
      unique case (paddr)
         IAWM_CTRL_ADDR: rd_word[IAWM_CTRL_EN_BIT] = gate_en;
         IAWM_STAT_ADDR: rd_word[1:0] = {cam_edge_seen, overlap_detected};
         IAWM_OFFSET_ADDR: rd_word = 32'(zero_to_first_cylinder_offset);
         IAWM_DI_SEL0_ADDR: begin
            for (int i = 0; i < 8; i++) begin
               rd_word[i * 4 +: 4] = direct_channel_reference_select[i];
            end
         end
         IAWM_DI_SEL1_ADDR: begin
            for (int i = 8; i < IAWM_DI_CHANS; i++) begin
               rd_word[(i - 8) * 4 +: 4] = direct_channel_reference_select[i];
            end
         end
         IAWM_PFI_SEL_ADDR: begin
            for (int i = 0; i < IAWM_PFI_CHANS; i++) begin
               rd_word[i * 4 +: 4] = port_channel_reference_select[i];
            end
            rd_word[IAWM_CAM_REF_LSB +: 4] = cam_capture_reference_select;
         end
         IAWM_PFI_WIN_ADDR: rd_word = {5'h00, port_module_window.stop,
                                       5'h00, port_module_window.start};
         IAWM_CAM_WIN_ADDR: rd_word = {5'h00, cam_window.stop, 5'h00, cam_window.start};
         IAWM_CAM_EDGE_ADDR: rd_word = 32'(first_cam_edge_angle);
         default: begin
            hit = 1'b0;
            for (int i = 0; i < IAWM_TDC_NUM; i++) begin
               if (paddr == IAWM_TDC_BASE + 8'(4 * i)) begin
                  rd_word = 32'(cylinder_top_center_angle[i]);
                  hit = 1'b1;
               end
            end
            for (int i = 0; i < IAWM_DI_MODS; i++) begin
               if (paddr == IAWM_DI_WIN_BASE + 8'(4 * i)) begin
                  rd_word = {5'h00, direct_module_window[i].stop,
                             5'h00, direct_module_window[i].start};
                  hit = 1'b1;
               end
            end
         end
      endcase
   end

   // Answer lands one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= access & ~pready;
         pslverr <= access & ~pready & ~hit;
         prdata <= (access & ~pready & ~pwrite & hit) ? rd_word : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_cam_hit;
      cam_rise && cam_in;
   endsequence

   sequence s_cam_logged;
      cam_edge_seen && (first_cam_edge_angle == $past(cam_signed));
   endsequence

   a_di_one_active: assert property (
      $onehot0(di_fire[2:0]) && $onehot0(di_fire[5:3])
      && $onehot0(di_fire[8:6]) && $onehot0(di_fire[11:9]))
      else $error("two direct channels of one module fire together");

   a_pfi_one_active: assert property ($onehot0(pfi_fire))
      else $error("two port channels fire together");

   a_di_window_gate: assert property (
      ((di_fire & ~$past(di_request & di_in)) == 12'h000))
      else $error("direct channel fired outside its window");

   a_pfi_window_gate: assert property (
      (pfi_fire & ~$past(pfi_request & pfi_in)) == 4'h0)
      else $error("port channel fired outside its window");

   a_di_overlap_flag: assert property ((|di_multi) |=> overlap_detected)
      else $error("direct window overlap not flagged");

   a_pfi_overlap_flag: assert property (pfi_multi |=> overlap_detected)
      else $error("port window overlap not flagged");

   a_cam_edge_capture: assert property (s_cam_hit |=> s_cam_logged)
      else $error("cam edge in window not captured");

   a_cam_window_bound: assert property (
      (cam_rise && !cam_in) |=> $stable(first_cam_edge_angle))
      else $error("cam edge outside window was captured");

   a_cam_window_close: assert property (
      !cam_in |-> ##1 ($stable(first_cam_edge_angle) || $past(cam_in)))
      else $error("capture changed while window closed");

   a_angle_wrap_range: assert property (
      (cam_degrees_before_top_center < 10'h2D0) && (tc_abs[0] < 10'h2D0))
      else $error("angle left one engine cycle");

endmodule

// >>> iawm_pkg.sv
// Constants, register map and shared types of the injection angle window mapper
package iawm_pkg;
   // One four-stroke engine cycle in crank angle degrees
   localparam logic signed [13:0] IAWM_CYCLE = 14'sh02D0;
   localparam logic [9:0] IAWM_HALF_CYCLE = 10'h168;
   localparam int IAWM_TDC_NUM = 12;
   localparam int IAWM_DI_MODS = 4;
   localparam int IAWM_DI_CHANS = 12;
   localparam int IAWM_PFI_CHANS = 4;
   localparam int IAWM_WRAP_STEPS = 4;

   // Register byte addresses
   localparam logic [7:0] IAWM_CTRL_ADDR = 8'h00;
   localparam logic [7:0] IAWM_STAT_ADDR = 8'h04;
   localparam logic [7:0] IAWM_OFFSET_ADDR = 8'h08;
   localparam logic [7:0] IAWM_TDC_BASE = 8'h10;
   localparam logic [7:0] IAWM_DI_SEL0_ADDR = 8'h40;
   localparam logic [7:0] IAWM_DI_SEL1_ADDR = 8'h44;
   localparam logic [7:0] IAWM_PFI_SEL_ADDR = 8'h48;
   localparam logic [7:0] IAWM_DI_WIN_BASE = 8'h50;
   localparam logic [7:0] IAWM_PFI_WIN_ADDR = 8'h60;
   localparam logic [7:0] IAWM_CAM_WIN_ADDR = 8'h64;
   localparam logic [7:0] IAWM_CAM_EDGE_ADDR = 8'h68;

   // Field positions
   localparam int IAWM_CTRL_EN_BIT = 0;
   localparam int IAWM_STAT_OVL_BIT = 0;
   localparam int IAWM_STAT_CAM_BIT = 1;
   localparam int IAWM_WIN_START_LSB = 0;
   localparam int IAWM_WIN_STOP_LSB = 16;
   localparam int IAWM_SEL_WIDTH = 4;
   localparam int IAWM_CAM_REF_LSB = 16;

   // Window as a pair of degrees-before-top-center angles
   typedef struct packed {
      logic signed [10:0] start;
      logic signed [10:0] stop;
   } iawm_window_t;

   // Reset values
   localparam logic IAWM_CTRL_EN_RST = 1'b1;
   localparam logic signed [10:0] IAWM_OFFSET_RST = 11'sh000;
   localparam logic signed [10:0] IAWM_TDC_RST [IAWM_TDC_NUM] = '{
      11'sh000, 11'sh0F0, 11'sh1E0, 11'sh03C, 11'sh12C, 11'sh21C,
      11'sh078, 11'sh168, 11'sh258, 11'sh0B4, 11'sh1A4, 11'sh294};
   localparam iawm_window_t IAWM_DI_WIN_RST = '{start: 11'sh03C, stop: 11'sh7C4};
   localparam iawm_window_t IAWM_PFI_WIN_RST = '{start: 11'sh136, stop: 11'sh0FA};
   localparam iawm_window_t IAWM_CAM_WIN_RST = '{start: 11'sh03C, stop: 11'sh7C4};
   localparam logic [3:0] IAWM_CAM_REF_RST = 4'h0;
endpackage

// >>> iawm_sensor_model.sv
// Crank and cam sensor model: tracker angle, sync flag and first cam input
`timescale 1ns/1ps
module iawm_sensor_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic [9:0] load_angle,
   input wire logic cam_req,
   output logic [9:0] engine_angle,
   output logic angle_valid,
   output logic cam1_in
);
   ////////////////////////////////////////////////////////////////////////////////
   // Tracker jumps to the commanded angle; sync only after the first position
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         engine_angle <= 10'h000;
         angle_valid <= 1'b0;
      end else if (load) begin
         engine_angle <= (load_angle > 10'h2CF) ? 10'h000 : load_angle;
         angle_valid <= 1'b1;
      end
   end
   // Cam level registered, so a rise lands one clock after cam_req goes high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cam1_in <= 1'b0;
      end else begin
         cam1_in <= cam_req;
      end
   end
endmodule

// >>> test_injection_angle_window_mapper.sv
// Self-checking bench for the injection angle window mapper
`timescale 1ns/1ps
module test_injection_angle_window_mapper;
   import iawm_pkg::*;
   typedef struct {string name; logic [32:0] exp;} iawm_note_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, snap;
   logic angle_load, angle_valid, cam_req, cam1_in, overlap_detected, cam_edge_seen;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [9:0] engine_angle, load_angle;
   logic [11:0] di_request, di_fire;
   logic [3:0] pfi_request, pfi_fire;
   logic signed [10:0] first_cam_edge_angle;
   int failures, check_count, seed, off, a, cam_exp;
   int di_ref [12];
   int pf_ref [4];
   iawm_note_t notes [$];

   iawm_mapper u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .engine_angle(engine_angle), .angle_valid(angle_valid),
      .di_request(di_request), .pfi_request(pfi_request), .cam1_in(cam1_in),
      .di_fire(di_fire), .pfi_fire(pfi_fire), .overlap_detected(overlap_detected),
      .cam_edge_seen(cam_edge_seen), .first_cam_edge_angle(first_cam_edge_angle));
   iawm_sensor_model u_sensor (.pclk(pclk), .presetn(presetn), .load(angle_load),
      .load_angle(load_angle), .cam_req(cam_req), .engine_angle(engine_angle),
      .angle_valid(angle_valid), .cam1_in(cam1_in));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, 40 ns period
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // Circular window test, both ends inclusive
   function automatic logic inwin(int st, int sp, int tc, int ang);
      int d;
      d = (((tc - ang) % 720) + 720) % 720;
      return ((((st - d) % 720) + 720) % 720) <= ((((st - sp) % 720) + 720) % 720);
   endfunction

   // Gated outputs expected with no overlap and no cam capture yet
   function automatic logic [17:0] expect_fire(int ang, logic en);
      logic [17:0] v;
      v = 18'h00000;
      for (int k = 0; k < 12; k++) begin
         v[k] = en & di_request[k] & inwin(60, -60, off + di_ref[k], ang);
      end
      for (int k = 0; k < 4; k++) begin
         v[12 + k] = en & pfi_request[k] & inwin(310, 250, off + pf_ref[k], ang);
      end
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Bus master: request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d,
                      input logic [32:0] e, input string n);
      @(posedge pclk);
      if (!wr) notes.push_back('{n, e});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No cycle count assumed; only the watchdog ends a stuck wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Move the crank and give the registered gate time to settle
   task automatic at(input int ang);
      load_angle <= 10'(ang);
      angle_load <= 1'b1;
      @(posedge pclk);
      angle_load <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask

   // Note the expected angle, flags and fires, then flag the monitor to look
   task automatic chk(input logic [17:0] e, input string n);
      notes.push_back('{n, {4'h0, 11'(cam_exp), e}});
      snap <= 1'b1;
      @(posedge pclk);
      snap <= 1'b0;
   endtask

   // One cam rise at the given crank angle
   task automatic cam(input int ang);
      cam_req <= 1'b0;
      at(ang);
      cam_req <= 1'b1;
      repeat (3) @(posedge pclk);
      cam_req <= 1'b0;
   endtask

   task automatic end_of_test;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Monitor: oldest note against each read answer or snapshot
   always @(posedge pclk) begin
      logic [32:0] got;
      iawm_note_t nt;
      if ((psel && penable && pready === 1'b1 && !pwrite) || snap) begin
         got = snap ? {4'h0, first_cam_edge_angle, overlap_detected, cam_edge_seen,
                       pfi_fire, di_fire}
                    : {pslverr, prdata};
         nt = notes.pop_front();
         check_count++;
         if (got !== nt.exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", nt.name, nt.exp, got);
         end
      end
   end

   // Watchdog well beyond the few hundred cycles the sequence needs
   initial begin
      repeat (8000) @(posedge pclk);
      failures++;
      end_of_test;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      seed = 32'h0643;
      {psel, penable, pwrite, snap, angle_load, cam_req} = 6'h00;
      {paddr, pwdata, load_angle, di_request, pfi_request} = '0;
      presetn = 1'b0;
      off = 0;
      for (int k = 0; k < 12; k++) di_ref[k] = IAWM_TDC_RST[k];
      pf_ref = '{0, 180, 360, 540};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, IAWM_OFFSET_ADDR, 32'h0, 33'h0, "offset");
      for (int k = 0; k < 12; k++) begin
         apb(1'b0, IAWM_TDC_BASE + 8'(4 * k), 32'h0, {22'h0, IAWM_TDC_RST[k]}, "tdc");
      end
      apb(1'b0, 8'h6C, 32'h0, {1'b1, 32'h0}, "unmapped");
      apb(1'b1, IAWM_DI_WIN_BASE, 32'h07C4_003C, '0, "");
      apb(1'b0, IAWM_DI_WIN_BASE, 32'h0, 33'h0_07C4_003C, "di_window");
      // Out-of-range selector on the last channel falls back to the first top center
      apb(1'b1, IAWM_DI_SEL1_ADDR, 32'h0000_FA98, '0, "");
      di_ref[11] = 0;
      apb(1'b1, IAWM_PFI_SEL_ADDR, 32'h0000_5790, '0, "");
      di_request <= 12'hFFF;
      pfi_request <= 4'hF;
      repeat (16) begin
         a = (($random(seed) % 720) + 720) % 720;
         at(a);
         chk(expect_fire(a, 1'b1), "fire");
      end
      // Remapped selector and negative offset, window edges
      apb(1'b1, IAWM_DI_SEL0_ADDR, 32'h7654_3213, '0, "");
      apb(1'b1, IAWM_OFFSET_ADDR, 32'hFFFF_FFF6, '0, "");
      off = -10;
      di_ref[0] = 60;
      foreach (pf_ref[i]) begin
         a = (i == 0) ? 50 : (i == 1) ? 110 : (i == 2) ? 111 : 700;
         at(a);
         chk(expect_fire(a, 1'b1), "edge");
      end
      // Two channels of one module on one angle
      apb(1'b1, IAWM_DI_SEL0_ADDR, 32'h7654_3200, '0, "");
      di_request <= 12'h003;
      pfi_request <= 4'h0;
      at(0);
      chk({2'b10, 4'h0, 12'h001}, "one_at_a_time");
      apb(1'b1, IAWM_DI_SEL0_ADDR, 32'h7654_3213, '0, "");
      apb(1'b1, IAWM_PFI_WIN_ADDR, 32'h0000_00C8, '0, "");
      di_request <= 12'h000;
      at(520); // Two port windows open together here
      chk({2'b10, 16'h0000}, "port_overlap");
      apb(1'b1, IAWM_PFI_WIN_ADDR, 32'h00FA_0136, '0, "");
      apb(1'b1, IAWM_CTRL_ADDR, 32'h0, '0, "");
      di_request <= 12'hFFF;
      pfi_request <= 4'hF;
      at(700);
      chk(expect_fire(700, 1'b0), "disabled");
      apb(1'b1, IAWM_CTRL_ADDR, 32'h1, '0, "");
      at(700);
      chk(expect_fire(700, 1'b1), "enabled");
      // Cam capture against the fourth top center
      apb(1'b1, IAWM_PFI_SEL_ADDR, 32'h0003_5790, '0, "");
      di_request <= 12'h000;
      pfi_request <= 4'h0;
      cam(20);
      apb(1'b0, IAWM_CAM_EDGE_ADDR, 32'h0, 33'h0_0000_001E, "cam_first");
      cam_exp = 30;
      chk({2'b01, 16'h0000}, "cam_seen");
      cam(100);
      apb(1'b0, IAWM_CAM_EDGE_ADDR, 32'h0, 33'h0_FFFF_FFCE, "cam_late");
      cam(111);
      apb(1'b0, IAWM_CAM_EDGE_ADDR, 32'h0, 33'h0_FFFF_FFCE, "cam_closed");
      apb(1'b1, IAWM_STAT_ADDR, 32'h2, '0, "");
      apb(1'b0, IAWM_STAT_ADDR, 32'h0, 33'h0, "status");
      end_of_test;
   end
endmodule
